//--- src/cma_align.sv
`timescale 1ns/1ps
module cma_align
    import cma_pkg::*;
#(
    parameter int SEARCH_LEN = SEARCH_CYCLES,
    parameter bit EBIT_OPTION2 = 1'b0
)
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic ce_i,
    input wire logic link_clk_i,
    input wire cma_rx_t rx_i,
    input wire logic ebit_slot_i,
    output cma_tx_t tx_o,
    output cma_status_t status_o
);
    localparam int SRCH_W = $clog2(SEARCH_LEN + 1);

    if (SEARCH_LEN < 2)
    begin : g_bad_len
        $error("SEARCH_LEN too small");
    end

    // link domain reset, synchronised from the system reset
    logic lrst_s1;
    logic link_rst;

    always_ff @(posedge link_clk_i)
    begin
        lrst_s1 <= reset_i;
        link_rst <= lrst_s1;
    end

    cma_state_t state, next_state;
    logic [3:0] fidx, next_fidx;
    logic [5:0] sr6, next_sr6;
    logic [WIN_W-1:0] win, next_win;
    logic [3:0] rxc, next_rxc;
    logic [3:0] crc_prev, next_crc_prev;
    logic [1:0] smf_valid, next_smf_valid;
    logic [BLK_W-1:0] smf_cnt, next_smf_cnt;
    logic [BLK_W-1:0] err_cnt, next_err_cnt;
    logic [PEND_W-1:0] pending, next_pending;
    logic crc_rai, next_crc_rai;
    logic search, next_search;
    cma_tx_t tx, next_tx;
    logic [3:0] crc_now;
    logic [5:0] cand;
    logic [3:0] idx_inc;
    logic smf_start;
    logic smf_err;
    logic crc_bit;
    logic to_s1;
    logic timeout_l;

    cma_crc4 u_crc (
        .clk_i(link_clk_i),
        .reset_i(link_rst),
        .start_i(smf_start),
        .data_i(crc_bit),
        .crc_o(crc_now)
    );

    always_comb
    begin
        next_state = state;
        next_fidx = fidx;
        next_sr6 = sr6;
        next_win = win;
        next_rxc = rxc;
        next_crc_prev = crc_prev;
        next_smf_valid = smf_valid;
        next_smf_cnt = smf_cnt;
        next_err_cnt = err_cnt;
        next_crc_rai = crc_rai;
        smf_err = 1'b0;
        cand = {sr6[4:0], rx_i.data};
        idx_inc = fidx + 4'h1;
        smf_start = rx_i.frame_start && (state == ST_ALIGNED)
            && (idx_inc == SMF_FIRST_A || idx_inc == SMF_FIRST_B);
        crc_bit = (rx_i.frame_start && rx_i.fas_frame) ? 1'b0 : rx_i.data;
        if (rx_i.frame_start)
            next_fidx = idx_inc;
        if (rx_i.frame_start && !rx_i.fas_frame)
            next_sr6 = cand;
        unique case (state)
            ST_HUNT:
            begin
                if (rx_i.frame_start && !rx_i.fas_frame && cand == MULTIFRAME_ALIGN_PATTERN_PATTERN)
                begin
                    next_fidx = MULTIFRAME_ALIGN_PATTERN_LAST_FRAME;
                    next_win = '0;
                    next_state = ST_CONFIRM;
                end
            end
            ST_CONFIRM:
            begin
                if (rx_i.frame_start)
                begin
                    next_win = win + WIN_W'(1);
                    if (!rx_i.fas_frame && idx_inc == MULTIFRAME_ALIGN_PATTERN_LAST_FRAME
                        && cand == MULTIFRAME_ALIGN_PATTERN_PATTERN)
                    begin
                        next_state = ST_ALIGNED;
                        next_crc_rai = 1'b0;
                        next_smf_valid = 2'h0;
                        next_smf_cnt = '0;
                        next_err_cnt = '0;
                    end
                    else if (win >= WIN_W'(WIN_FRAMES - 1))
                        next_state = ST_HUNT;
                end
            end
            ST_ALIGNED:
            begin
                if (smf_start)
                begin
                    // check bits of the last block cover the block before it
                    if (smf_valid == 2'h2)
                    begin
                        smf_err = (rxc != crc_prev);
                        next_smf_cnt = (smf_cnt == BLK_W'(SMF_BLOCK - 1)) ? '0
                            : smf_cnt + BLK_W'(1);
                        next_err_cnt = (smf_cnt == BLK_W'(SMF_BLOCK - 1)) ? '0
                            : err_cnt + BLK_W'(smf_err);
                        if (smf_err && err_cnt >= BLK_W'(ERR_LIMIT - 1))
                        begin
                            next_state = ST_HUNT;
                            next_crc_rai = 1'b1;
                        end
                    end
                    else
                        next_smf_valid = smf_valid + 2'h1;
                    next_crc_prev = crc_now;
                    next_rxc = {3'h0, rx_i.data};
                end
                else if (rx_i.frame_start && rx_i.fas_frame)
                    next_rxc = {rxc[2:0], rx_i.data};
            end
        endcase
        if (!rx_i.basic_align)
            next_state = ST_HUNT;
    end

    // one pending report per errored block, drained one E slot at a time
    always_comb
    begin
        next_pending = pending;
        if (smf_err && !(ebit_slot_i && pending != '0) && pending != '1)
            next_pending = pending + PEND_W'(1);
        else if (!smf_err && ebit_slot_i && pending != '0)
            next_pending = pending - PEND_W'(1);
        if (!rx_i.basic_align)
            next_pending = '0;
        next_search = rx_i.basic_align && next_state != ST_ALIGNED;
        next_tx.mf_aligned = next_state == ST_ALIGNED;
        next_tx.remote_alarm_indication = !rx_i.basic_align || timeout_l || next_crc_rai;
        if (rx_i.basic_align)
            next_tx.e_bit = next_pending == '0;
        else
            next_tx.e_bit = !EBIT_OPTION2;
    end

    always_ff @(posedge link_clk_i)
    begin
        if (link_rst)
        begin
            state <= ST_HUNT;
            fidx <= 4'h0;
            sr6 <= 6'h3F;
            win <= '0;
            rxc <= 4'h0;
            crc_prev <= 4'h0;
            smf_valid <= 2'h0;
            smf_cnt <= '0;
            err_cnt <= '0;
            crc_rai <= 1'b0;
            pending <= '0;
            search <= 1'b0;
            tx <= '{e_bit: 1'b1, remote_alarm_indication: 1'b1, mf_aligned: 1'b0};
        end
        else
        begin
            state <= next_state;
            fidx <= next_fidx;
            sr6 <= next_sr6;
            win <= next_win;
            rxc <= next_rxc;
            crc_prev <= next_crc_prev;
            smf_valid <= next_smf_valid;
            smf_cnt <= next_smf_cnt;
            err_cnt <= next_err_cnt;
            crc_rai <= next_crc_rai;
            pending <= next_pending;
            search <= next_search;
            tx <= next_tx;
        end
    end

    assign tx_o = tx;

    // system clock side: the long search timer lives here, link clock may stop
    logic srch_s1, srch_s2;
    logic [SRCH_W-1:0] srch_cnt, next_srch_cnt;
    logic timeout, next_timeout;
    logic [1:0] st_s1;
    cma_status_t status, next_status;

    always_comb
    begin
        next_srch_cnt = srch_cnt;
        next_timeout = timeout;
        if (!srch_s2)
        begin
            next_srch_cnt = '0;
            next_timeout = 1'b0;
        end
        else if (srch_cnt == SRCH_W'(SEARCH_LEN - 1))
            next_timeout = 1'b1;
        else
            next_srch_cnt = srch_cnt + SRCH_W'(1);
        next_status.mf_aligned = st_s1[1];
        next_status.remote_alarm_indication = st_s1[0];
        next_status.search_timeout = timeout;
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
        begin
            srch_s1 <= 1'b0;
            srch_s2 <= 1'b0;
            srch_cnt <= '0;
            timeout <= 1'b0;
            st_s1 <= 2'h1;
            status <= '{mf_aligned: 1'b0, search_timeout: 1'b0, remote_alarm_indication: 1'b1};
        end
        else if (ce_i)
        begin
            srch_s1 <= search;
            srch_s2 <= srch_s1;
            srch_cnt <= next_srch_cnt;
            timeout <= next_timeout;
            st_s1 <= {tx.mf_aligned, tx.remote_alarm_indication};
            status <= next_status;
        end
    end

    assign status_o = status;

    // timeout level back into the link domain
    always_ff @(posedge link_clk_i)
    begin
        if (link_rst)
        begin
            to_s1 <= 1'b0;
            timeout_l <= 1'b0;
        end
        else
        begin
            to_s1 <= timeout;
            timeout_l <= to_s1;
        end
    end

    sequence s_err_at_limit;
        smf_err && err_cnt >= BLK_W'(ERR_LIMIT - 1);
    endsequence

    sequence s_hunt_alarm;
        state == ST_HUNT && crc_rai && tx.remote_alarm_indication;
    endsequence

    a_multiframe_align_pattern_bit_pos: assert property (@(posedge link_clk_i) disable iff (link_rst)
        (sr6 != $past(sr6)) |-> $past(rx_i.frame_start && !rx_i.fas_frame))
        else $error("pattern register moved outside a non-FAS bit one");

    a_align_window: assert property (@(posedge link_clk_i) disable iff (link_rst)
        $rose(state == ST_ALIGNED) |-> $past(state == ST_CONFIRM)
            && $past(win) < WIN_W'(WIN_FRAMES))
        else $error("alignment declared outside the confirm window");

    a_search_quiet: assert property (@(posedge clk_i) disable iff (reset_i)
        $rose(timeout) |-> $past(srch_cnt) == SRCH_W'(SEARCH_LEN - 1) && srch_s2)
        else $error("search timeout before full period");

    a_timeout_alarm: assert property (@(posedge link_clk_i) disable iff (link_rst)
        timeout_l |=> tx.remote_alarm_indication)
        else $error("no alarm after search timeout");

    a_err_queued: assert property (@(posedge link_clk_i) disable iff (link_rst)
        (smf_err && !ebit_slot_i && rx_i.basic_align && pending != '1)
            |=> pending == $past(pending) + PEND_W'(1) && !tx.e_bit)
        else $error("crc error not queued as cleared E bit");

    a_ebit_idle: assert property (@(posedge link_clk_i) disable iff (link_rst)
        (pending == '0 && !smf_err && rx_i.basic_align) |=> tx.e_bit)
        else $error("E bit cleared with no error pending");

    a_one_per_err: assert property (@(posedge link_clk_i) disable iff (link_rst)
        (ebit_slot_i && pending != '0 && !smf_err && rx_i.basic_align)
            |=> pending == $past(pending) - PEND_W'(1))
        else $error("E slot did not consume exactly one report");

    a_crc_loss: assert property (@(posedge link_clk_i) disable iff (link_rst)
        ((state == ST_ALIGNED) and s_err_at_limit) |=> s_hunt_alarm)
        else $error("excessive crc errors did not drop alignment");

    a_keep_below: assert property (@(posedge link_clk_i) disable iff (link_rst)
        (state == ST_ALIGNED && rx_i.basic_align && err_cnt < BLK_W'(ERR_LIMIT - 1))
            |=> state == ST_ALIGNED)
        else $error("alignment dropped below error limit");

    a_basic_loss: assert property (@(posedge link_clk_i) disable iff (link_rst)
        !rx_i.basic_align |=> tx.remote_alarm_indication && tx.e_bit == !EBIT_OPTION2 && pending == '0)
        else $error("basic alignment loss output wrong");

endmodule : cma_align

//--- src/cma_pkg.sv
package cma_pkg;

    // link framing
    localparam int FRAME_US = 125;
    localparam int FRAMES_PER_MF = 16;
    localparam logic [3:0] SMF_FIRST_A = 4'h0;
    localparam logic [3:0] SMF_FIRST_B = 4'h8;
    localparam logic [3:0] MULTIFRAME_ALIGN_PATTERN_LAST_FRAME = 4'hB;
    localparam logic [5:0] MULTIFRAME_ALIGN_PATTERN_PATTERN = 6'h0B;

    // second pattern must follow within this time, counted in frames (rounded down)
    localparam int MF_WINDOW_US = 8000;
    localparam int WIN_FRAMES = MF_WINDOW_US / FRAME_US;
    localparam int WIN_W = 7;

    // search period before the alarm, counted in system clock cycles
    localparam int CLK_MHZ = 200;
    localparam int SEARCH_MS = 500;
    localparam int SEARCH_CYCLES = SEARCH_MS * 1000 * CLK_MHZ;

    // excessive crc error criterion
    localparam int SMF_BLOCK = 1000;
    localparam int ERR_LIMIT = 915;
    localparam int BLK_W = 10;

    // crc generator x^4+x+1, feedback taps below x^4
    localparam logic [3:0] CRC_POLY = 4'h3;
    localparam int PEND_W = 3;

    typedef enum logic [1:0] {
        ST_HUNT,
        ST_CONFIRM,
        ST_ALIGNED
    } cma_state_t;

    typedef struct packed {
        logic data;
        logic frame_start;
        logic fas_frame;
        logic basic_align;
    } cma_rx_t;

    typedef struct packed {
        logic e_bit;
        logic remote_alarm_indication;
        logic mf_aligned;
    } cma_tx_t;

    typedef struct packed {
        logic mf_aligned;
        logic search_timeout;
        logic remote_alarm_indication;
    } cma_status_t;

endpackage : cma_pkg

//--- src/cma_crc4.sv
`timescale 1ns/1ps
module cma_crc4
    import cma_pkg::*;
(
    input wire logic clk_i,
    input wire logic reset_i,
    input wire logic start_i,
    input wire logic data_i,
    output logic [3:0] crc_o
);
    logic [3:0] crc;
    logic [3:0] next_crc;
    logic [3:0] base;
    logic fb;

    // start seeds zero so the first bit of a block is already included
    always_comb
    begin
        base = start_i ? 4'h0 : crc;
        fb = base[3] ^ data_i;
        next_crc = {base[2:0], 1'b0} ^ (fb ? CRC_POLY : 4'h0);
    end

    always_ff @(posedge clk_i)
    begin
        if (reset_i)
            crc <= 4'h0;
        else
            crc <= next_crc;
    end

    assign crc_o = crc;

endmodule : cma_crc4

//--- sim/cma_far_end.sv
`timescale 1ns/1ps
module cma_far_end
    import cma_pkg::*;
(
    input wire logic link_clk_i,
    input wire logic reset_i,
    input wire logic multiframe_align_pattern_ok_i,
    input wire logic bad_i,
    input wire logic basic_i,
    output cma_rx_t rx_o,
    output logic slot_o,
    output logic smf_o
);
    logic [7:0] bit_cnt;
    logic [3:0] frm;
    logic [3:0] crc;
    logic [3:0] chk;
    logic bad;
    logic d;
    logic fb;
    always @(posedge link_clk_i)
    begin
        // restart mid-frame so no frame starts right at reset release
        if (reset_i)
        begin
            bit_cnt = 8'h01;
            frm = 4'h0;
            crc = 4'h0;
            chk = 4'h0;
        end
        if (bit_cnt == 8'h00 && frm[2:0] == 3'h0)
        begin
            chk = crc;
            crc = 4'h0;
            bad = bad_i;
        end
        d = bit_cnt[0] ^ bit_cnt[3] ^ frm[1];
        if (bit_cnt == 8'h00)
        begin
            if (!frm[0])
                d = chk[3 - frm[2:1]] ^ (bad && frm[2:1] == 2'h0);
            else if (frm < 4'hC)
                d = MULTIFRAME_ALIGN_PATTERN_PATTERN[5 - frm[3:1]] ^ !multiframe_align_pattern_ok_i;
            else
                d = 1'b1;
        end
        fb = crc[3] ^ (d && !(bit_cnt == 8'h00 && !frm[0]));
        crc = {crc[2:0], 1'b0} ^ (fb ? 4'h3 : 4'h0);
        rx_o.data <= #1 d;
        rx_o.frame_start <= #1 bit_cnt == 8'h00;
        rx_o.fas_frame <= #1 !frm[0];
        rx_o.basic_align <= #1 basic_i;
        slot_o <= #1 bit_cnt == 8'h00 && frm[2:0] == 3'h5;
        smf_o <= #1 bit_cnt == 8'h00 && frm[2:0] == 3'h0;
        bit_cnt = bit_cnt + 8'h01;
        if (bit_cnt == 8'h00)
            frm = frm + 4'h1;
    end
endmodule : cma_far_end

//--- sim/testbench.sv
`timescale 1ns/1ps
module testbench
    import cma_pkg::*;
;
    localparam int SLEN = 2000;
    logic clk = 1'b0;
    logic link_clk;
    logic reset = 1'b1;
    logic multiframe_align_pattern_ok = 1'b0;
    logic bad = 1'b0;
    logic basic = 1'b1;
    logic slot;
    logic crc_submultiframe;
    logic last_e = 1'b1;
    cma_rx_t rx;
    cma_tx_t tx;
    cma_status_t status;
    int failures = 0;
    int n_tests = 0;
    int zeros = 0;
    int runs = 0;

    always #2.5 clk = ~clk;
    initial
    begin
        link_clk = 1'b0;
        #7;
        forever #16 link_clk = ~link_clk;
    end

    cma_align #(.SEARCH_LEN(SLEN)) uut (.clk_i(clk), .reset_i(reset), .ce_i(1'b1),
        .link_clk_i(link_clk), .rx_i(rx), .ebit_slot_i(slot), .tx_o(tx), .status_o(status));
    cma_far_end far (.link_clk_i(link_clk), .reset_i(reset), .multiframe_align_pattern_ok_i(multiframe_align_pattern_ok),
        .bad_i(bad), .basic_i(basic), .rx_o(rx), .slot_o(slot), .smf_o(crc_submultiframe));

    // count cleared E bits and runs of them as the transmitter takes them
    always @(posedge link_clk)
    begin
        if (slot)
        begin
            if (tx.e_bit !== 1'b1)
            begin
                zeros++;
                if (last_e)
                    runs++;
            end
            last_e = tx.e_bit;
        end
    end

    task check(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
            failures++;
        end
    endtask : check

    task wait_clk(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : wait_clk

    task wait_link(input int n);
        repeat (n) @(posedge link_clk);
        #1;
    endtask : wait_link

    task wait_smf(input int n);
        repeat (n) @(posedge link_clk iff crc_submultiframe);
        #1;
    endtask : wait_smf

    task t_reset;
        check(tx.mf_aligned, 1'b0);
        check(status.mf_aligned, 1'b0);
        check(status.search_timeout, 1'b0);
        check(status.remote_alarm_indication, 1'b1);
    endtask : t_reset

    // wrong pattern keeps it hunting: quiet first, alarm after the search period
    task t_search;
        wait_clk(SLEN / 2);
        check(tx.remote_alarm_indication, 1'b0);
        check(status.search_timeout, 1'b0);
        wait_clk(SLEN);
        check(tx.remote_alarm_indication, 1'b1);
        check(status.search_timeout, 1'b1);
    endtask : t_search

    task t_align;
        int i;
        i = 0;
        multiframe_align_pattern_ok = 1'b1;
        while (tx.mf_aligned !== 1'b1 && i < 12288)
        begin
            wait_link(1);
            i++;
        end
        check(tx.mf_aligned, 1'b1);
        wait_link(8);
        check(tx.remote_alarm_indication, 1'b0);
        check(status.mf_aligned, 1'b1);
    endtask : t_align

    // first boundaries only prime the checker, so skip three before counting
    task t_crc;
        int z;
        int r;
        wait_smf(3);
        z = zeros;
        wait_smf(3);
        check(zeros - z, 0);
        z = zeros;
        r = runs;
        bad = 1'b1;
        wait_smf(1);
        bad = 1'b0;
        wait_smf(4);
        check(zeros - z, 1);
        check(runs - r, 1);
        z = zeros;
        r = runs;
        bad = 1'b1;
        wait_smf(2);
        bad = 1'b0;
        wait_smf(4);
        check(zeros - z, 2);
        check(runs - r, 1);
        check(tx.remote_alarm_indication, 1'b0);
    endtask : t_crc

    task t_basic;
        int z;
        basic = 1'b0;
        wait_link(3);
        check(tx.remote_alarm_indication, 1'b1);
        check(tx.e_bit, 1'b1);
        z = zeros;
        wait_smf(2);
        check(zeros - z, 0);
        check(status.remote_alarm_indication, 1'b1);
    endtask : t_basic

    task finish_test;
        $display("tests %0d failures %0d", n_tests, failures);
        if (failures == 0 && n_tests > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : finish_test

    initial
    begin
        #3000000;
        failures++;
        finish_test;
    end

    // reset spans three link edges as well, hence longer than eight cycles
    initial
    begin
        wait_clk(20);
        t_reset;
        reset = 1'b0;
        t_search;
        t_align;
        t_crc;
        t_basic;
        finish_test;
    end
endmodule : testbench
